// [core/timer8_regs.vh]
// constants for the 8-bit timer with one compare channel
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH
`define T8_BOTTOM 8'h00
`define T8_MAX 8'hFF
`define T8_CS_NONE 3'h0
`define T8_CS_DIV8 3'h2
`define T8_CS_DIV32 3'h3
`define T8_CS_DIV64 3'h4
`define T8_CS_DIV128 3'h5
`define T8_CS_DIV256 3'h6
`define T8_CS_DIV1024 3'h7
`define T8_WGM_NORMAL 2'h0
`define T8_WGM_PCPWM 2'h1
`define T8_WGM_CTC 2'h2
`define T8_WGM_FASTPWM 2'h3
`define T8_COM_NONE 2'h0
`define T8_COM_TOGGLE 2'h1
`define T8_COM_CLEAR 2'h2
`define T8_COM_SET 2'h3
`define T8_RST_BYTE 8'h00
`define T8_PRESC_W 10
`endif

// [core/timer8_tick_gen.v]
// timer clock tick generation: source select, 10-bit prescaler, stop
`timescale 1ns/1ps
`include "timer8_regs.vh"
module timer8_tick_gen
(
   input wire clk,
   input wire sys_rst,
   input wire async_clock_select,
   input wire osc_pin_in,
   input wire [2:0] clock_select_field,
   output wire osc_pin_out,
   output reg tick
);
   reg osc_s1_reg;
   reg osc_s2_reg;
   reg osc_s3_reg;
   reg [`T8_PRESC_W-1:0] presc_reg;
   wire src_edge;
   wire [`T8_PRESC_W-1:0] presc_next;
   // oscillator pin is outside the clock domain
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
      end
      else
      begin
         osc_s1_reg <= osc_pin_in;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
      end
   end
   // oscillator loop is external; output is inverted sync copy
   assign osc_pin_out = ~osc_s2_reg;
   assign src_edge = async_clock_select ? (osc_s2_reg & ~osc_s3_reg) : 1'b1;
   assign presc_next = presc_reg + {{(`T8_PRESC_W-1){1'b0}}, 1'b1};
   always @(posedge clk)
   begin
      if (sys_rst)
         presc_reg <= {`T8_PRESC_W{1'b0}};
      else if (src_edge)
         presc_reg <= presc_next;
   end
   always @*
   begin
      case (clock_select_field)
         `T8_CS_NONE: tick = 1'b0;
         3'h1: tick = src_edge;
         `T8_CS_DIV8: tick = src_edge & (presc_reg[2:0] == 3'h7);
         `T8_CS_DIV32: tick = src_edge & (presc_reg[4:0] == 5'h1F);
         `T8_CS_DIV64: tick = src_edge & (presc_reg[5:0] == 6'h3F);
         `T8_CS_DIV128: tick = src_edge & (presc_reg[6:0] == 7'h7F);
         `T8_CS_DIV256: tick = src_edge & (presc_reg[7:0] == 8'hFF);
         `T8_CS_DIV1024: tick = src_edge & (presc_reg == 10'h3FF);
         default: tick = 1'b0;
      endcase
   end
endmodule

// [core/timer8_wavegen.v]
// output compare state update on match or forced compare
`timescale 1ns/1ps
`include "timer8_regs.vh"
module timer8_wavegen
(
   input wire clk,
   input wire sys_rst,
   input wire [1:0] waveform_mode_field,
   input wire [1:0] compare_output_mode,
   input wire tick,
   input wire match_ok,
   input wire at_bottom,
   input wire force_ok,
   output reg compare_output_state
);
   reg state_next;
   wire pwm_mode;
   assign pwm_mode = waveform_mode_field[0];
   always @*
   begin
      state_next = compare_output_state;
      if (!pwm_mode)
      begin
         // forced or real match acts alike
         if ((tick & match_ok) | force_ok)
         begin
            case (compare_output_mode)
               `T8_COM_TOGGLE: state_next = ~compare_output_state;
               `T8_COM_CLEAR: state_next = 1'b0;
               `T8_COM_SET: state_next = 1'b1;
               default: state_next = compare_output_state;
            endcase
         end
      end
      else if (tick)
      begin
         // pwm: fast pwm com 2 non-inverted, 3 inverted; phase correct toggles for both; 1 reserved here
         if (waveform_mode_field == `T8_WGM_FASTPWM)
         begin
            if (match_ok)
               state_next = (compare_output_mode == `T8_COM_SET);
            else if (at_bottom)
               state_next = (compare_output_mode == `T8_COM_CLEAR);
         end
         else if (match_ok)
         begin
            state_next = ~compare_output_state;
         end
         if (compare_output_mode == `T8_COM_NONE ||
             compare_output_mode == `T8_COM_TOGGLE)
            state_next = compare_output_state;
      end
   end
   always @(posedge clk)
   begin
      if (sys_rst)
         compare_output_state <= 1'b0;
      else
         compare_output_state <= state_next;
   end
endmodule

// [core/timer8_counter_compare_unit.v]
// 8-bit timer/counter with one output compare channel
`timescale 1ns/1ps
`include "timer8_regs.vh"
module timer8_counter_compare_unit
(
   input wire clk,
   input wire sys_rst,
   input wire [2:0] clock_select_field,
   input wire [1:0] waveform_mode_field,
   input wire [1:0] compare_output_mode,
   input wire async_clock_select,
   input wire osc_pin_in,
   output wire osc_pin_out,
   input wire count_wr,
   input wire [7:0] count_wdata,
   output wire [7:0] count_value,
   input wire compare_wr,
   input wire [7:0] compare_wdata,
   output wire [7:0] compare_rdata,
   input wire force_compare_strobe,
   input wire compare_irq_enable,
   input wire overflow_irq_enable,
   input wire compare_flag_clr,
   input wire overflow_flag_clr,
   input wire compare_irq_ack,
   input wire overflow_irq_ack,
   output wire compare_match_flag,
   output wire overflow_flag,
   output wire [1:0] timer_flag_reg,
   output wire [1:0] timer_mask_reg,
   output wire compare_irq,
   output wire overflow_irq,
   input wire port_out,
   output wire pin_out
);
   reg [7:0] count_reg;
   reg [7:0] count_next;
   reg [7:0] compare_reg;
   reg [7:0] compare_next;
   reg [7:0] compare_buf_reg;
   reg [7:0] compare_buf_next;
   reg down_reg;
   reg down_next;
   reg cmp_flag_reg;
   reg ovf_flag_reg;
   reg block_reg;
   reg match_pend_reg;
   reg ovf_set;
   reg cmp_flag_next;
   reg ovf_flag_next;
   reg [7:0] rdata_reg;
   reg [7:0] rdata_next;
   wire tick;
   wire match;
   wire match_ok;
   wire buffered;
   wire at_top;
   wire at_bottom;
   wire at_max;
   wire [7:0] top_value;
   wire compare_output_state;
   wire cmp_clear;
   wire ovf_clear;
   wire cmp_set;

   timer8_tick_gen u_tick
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_clock_select(async_clock_select),
      .osc_pin_in(osc_pin_in),
      .clock_select_field(clock_select_field),
      .osc_pin_out(osc_pin_out),
      .tick(tick)
   );

   assign at_bottom = (count_reg == `T8_BOTTOM);
   assign at_max = (count_reg == `T8_MAX);
   assign top_value = (waveform_mode_field == `T8_WGM_CTC) ? compare_reg : `T8_MAX;
   assign at_top = (count_reg == top_value);
   assign match = (count_reg == compare_reg);
   // match blocked one timer clock after count write
   assign match_ok = match & ~block_reg;
   // pwm modes are the odd mode codes
   assign buffered = waveform_mode_field[0];

   always @*
   begin
      count_next = count_reg;
      down_next = down_reg;
      ovf_set = 1'b0;
      if (tick)
      begin
         case (waveform_mode_field)
            `T8_WGM_NORMAL:
            begin
               // wrap without clear, flag as it hits zero
               count_next = count_reg + 8'h01;
               down_next = 1'b0;
               ovf_set = at_max;
            end
            `T8_WGM_CTC:
            begin
               down_next = 1'b0;
               // a blocked match clears nothing either
               if (match_ok)
                  count_next = `T8_BOTTOM;
               else
                  count_next = count_reg + 8'h01;
               ovf_set = at_max;
            end
            `T8_WGM_FASTPWM:
            begin
               count_next = count_reg + 8'h01;
               down_next = 1'b0;
               ovf_set = at_max;
            end
            `T8_WGM_PCPWM:
            begin
               // turn at max going up, at bottom going down
               if (down_reg)
               begin
                  if (at_bottom)
                  begin
                     down_next = 1'b0;
                     count_next = count_reg + 8'h01;
                     ovf_set = 1'b1;
                  end
                  else
                     count_next = count_reg - 8'h01;
               end
               else if (at_max)
               begin
                  down_next = 1'b1;
                  count_next = count_reg - 8'h01;
               end
               else
                  count_next = count_reg + 8'h01;
            end
            default: count_next = count_reg;
         endcase
      end
      // cpu write wins over clear or count
      // the dropped tick leaves no turn and no overflow behind
      if (count_wr)
      begin
         count_next = count_wdata;
         down_next = down_reg;
         ovf_set = 1'b0;
      end
   end

   // update at top (fast pwm) or top of up-slope (phase correct)
   always @*
   begin
      compare_next = compare_reg;
      compare_buf_next = compare_buf_reg;
      if (buffered)
      begin
         if (tick && at_top)
            compare_next = compare_buf_reg;
         if (compare_wr)
            compare_buf_next = compare_wdata;
      end
      else
      begin
         // unbuffered writes go straight to active
         if (compare_wr)
            compare_next = compare_wdata;
         compare_buf_next = compare_next;
      end
   end

   assign cmp_clear = compare_flag_clr | compare_irq_ack;
   assign ovf_clear = overflow_flag_clr | overflow_irq_ack;

   // flag follows the pending match by one tick
   assign cmp_set = tick & match_pend_reg;

   // set beats clear, so an event in the clearing cycle is never lost
   always @*
   begin
      cmp_flag_next = cmp_flag_reg;
      ovf_flag_next = ovf_flag_reg;
      // force never reaches flag or count
      if (cmp_set)
         cmp_flag_next = 1'b1;
      else if (cmp_clear)
         cmp_flag_next = 1'b0;
      // overflow set beats its clear as well
      if (ovf_set)
         ovf_flag_next = 1'b1;
      else if (ovf_clear)
         ovf_flag_next = 1'b0;
   end

   // read view registered, so a mode change shows next edge
   always @*
   begin
      if (buffered)
         rdata_next = compare_buf_next;
      else
         rdata_next = compare_next;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         count_reg <= `T8_RST_BYTE;
         compare_reg <= `T8_RST_BYTE;
         compare_buf_reg <= `T8_RST_BYTE;
         down_reg <= 1'b0;
         cmp_flag_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
         block_reg <= 1'b0;
         match_pend_reg <= 1'b0;
         rdata_reg <= `T8_RST_BYTE;
      end
      else
      begin
         count_reg <= count_next;
         compare_reg <= compare_next;
         compare_buf_reg <= compare_buf_next;
         down_reg <= down_next;
         // block holds until one timer clock passes
         if (count_wr)
            block_reg <= 1'b1;
         else if (tick)
            block_reg <= 1'b0;
         // match seen now, flag at next timer clock
         if (tick)
            match_pend_reg <= match_ok;
         cmp_flag_reg <= cmp_flag_next;
         ovf_flag_reg <= ovf_flag_next;
         rdata_reg <= rdata_next;
      end
   end

   timer8_wavegen u_wave
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .waveform_mode_field(waveform_mode_field),
      .compare_output_mode(compare_output_mode),
      .tick(tick),
      .match_ok(match_ok),
      .at_bottom(at_bottom),
      .force_ok(force_compare_strobe),
      .compare_output_state(compare_output_state)
   );

   assign count_value = count_reg;
   assign compare_rdata = rdata_reg;
   assign compare_match_flag = cmp_flag_reg;
   assign overflow_flag = ovf_flag_reg;
   assign timer_flag_reg = {cmp_flag_reg, ovf_flag_reg};
   assign timer_mask_reg = {compare_irq_enable, overflow_irq_enable};
   assign compare_irq = cmp_flag_reg & compare_irq_enable;
   assign overflow_irq = ovf_flag_reg & overflow_irq_enable;
   // mode bits pick pin source immediately
   assign pin_out = (compare_output_mode != `T8_COM_NONE) ? compare_output_state : port_out;
endmodule

// [bench/timer8_properties.sv]
// concurrent checks on the timer compare unit ports
`timescale 1ns/1ps
module timer8_checker
(
   input wire clk,
   input wire sys_rst,
   input wire async_clock_select,
   input wire [2:0] clock_select_field,
   input wire [1:0] waveform_mode_field,
   input wire [1:0] compare_output_mode,
   input wire count_wr,
   input wire [7:0] count_wdata,
   input wire [7:0] count_value,
   input wire [7:0] compare_rdata,
   input wire force_compare_strobe,
   input wire compare_irq_enable,
   input wire overflow_irq_enable,
   input wire compare_irq_ack,
   input wire compare_match_flag,
   input wire overflow_flag,
   input wire [1:0] timer_flag_reg,
   input wire [1:0] timer_mask_reg,
   input wire compare_irq,
   input wire overflow_irq,
   input wire port_out,
   input wire pin_out
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // stopped for two cycles, though the tick is combinational and is already off in the first
   wire idle = clock_select_field == 3'h0;
   chk_stop_holds: assert property (idle && $past(idle) && !count_wr |=> $stable(count_value))
      else $error("count moved with no clock selected");
   chk_write_wins: assert property (count_wr |=> count_value == $past(count_wdata))
      else $error("count write not stored");
   chk_irq_gate: assert property (compare_irq == (compare_match_flag && compare_irq_enable)
      && overflow_irq == (overflow_flag && overflow_irq_enable))
      else $error("request not flag and enable");
   chk_shared_regs: assert property (timer_flag_reg == {compare_match_flag, overflow_flag}
      && timer_mask_reg == {compare_irq_enable, overflow_irq_enable})
      else $error("shared flag or mask bits wrong");
   chk_ack_clears: assert property (compare_irq_ack && idle && $past(idle)
      |=> !compare_match_flag)
      else $error("serviced flag not cleared");
   chk_pin_source: assert property (compare_output_mode == 2'h0 |-> pin_out == port_out)
      else $error("pin not from port logic");
   chk_force_quiet: assert property (force_compare_strobe && idle && $past(idle) && !count_wr
      && !compare_match_flag |=> !compare_match_flag && $stable(count_value))
      else $error("forced compare touched flag or count");
   chk_ovf_wrap: assert property (waveform_mode_field == 2'h0 && count_value == 8'hFF
      && !count_wr ##1 count_value == 8'h00 |-> overflow_flag)
      else $error("overflow flag missing at wrap");
   chk_ctc_clear: assert property (waveform_mode_field == 2'h2 && !async_clock_select
      && clock_select_field == 3'h1 && $past(clock_select_field) == 3'h1
      && count_value == compare_rdata && !count_wr && !$past(count_wr)
      |=> count_value == 8'h00)
      else $error("counter not cleared on match");
endmodule
bind timer8_counter_compare_unit timer8_checker chk_u (.clk, .sys_rst, .async_clock_select,
   .clock_select_field, .waveform_mode_field, .compare_output_mode, .count_wr, .count_wdata,
   .count_value, .compare_rdata, .force_compare_strobe, .compare_irq_enable,
   .overflow_irq_enable, .compare_irq_ack, .compare_match_flag, .overflow_flag,
   .timer_flag_reg, .timer_mask_reg, .compare_irq, .overflow_irq, .port_out, .pin_out);

// [bench/timer8_cpu_model.sv]
// cpu interrupt service: acknowledges a pending request after a latency
`timescale 1ns/1ps
module timer8_cpu_model
(
   input wire clk,
   input wire sys_rst,
   input wire enable,
   input wire [3:0] latency,
   input wire irq,
   output reg ack
);
   reg [3:0] wait_reg;
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         wait_reg <= 4'h0;
         ack <= 1'b0;
      end
      else
      begin
         ack <= 1'b0;
         wait_reg <= 4'h0;
         // one ack per request; the flag drops the cycle after
         if (enable && irq && !ack)
         begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg == latency)
            begin
               ack <= 1'b1;
               wait_reg <= 4'h0;
            end
         end
      end
   end
endmodule

// [bench/timer8_counter_compare_unit_tb_top.sv]
// self-checking bench for the 8-bit timer compare unit
`timescale 1ns/1ps
module timer8_counter_compare_unit_tb_top;
   reg clk = 1'b0, sys_rst = 1'b1, async_clock_select = 1'b0, osc_pin_in = 1'b0;
   reg count_wr = 1'b0, compare_wr = 1'b0, force_compare_strobe = 1'b0, port_out = 1'b1;
   reg compare_irq_enable = 1'b0, overflow_irq_enable = 1'b0, svc = 1'b0, pin_exp;
   reg compare_flag_clr = 1'b0, overflow_flag_clr = 1'b0;
   reg [2:0] clock_select_field = 3'h0;
   reg [1:0] waveform_mode_field = 2'h0, compare_output_mode = 2'h0;
   reg [7:0] count_wdata = 8'h00, compare_wdata = 8'h00, c, top_seen;
   wire osc_pin_out, compare_irq_ack, overflow_irq_ack, compare_match_flag, overflow_flag;
   wire compare_irq, overflow_irq, pin_out;
   wire [7:0] count_value, compare_rdata;
   wire [1:0] timer_flag_reg, timer_mask_reg;
   integer seed = 15581, err_count = 0, checked = 0, i;
   always #2 clk = ~clk;
   timer8_counter_compare_unit dut_u
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .clock_select_field(clock_select_field),
      .waveform_mode_field(waveform_mode_field),
      .compare_output_mode(compare_output_mode),
      .async_clock_select(async_clock_select),
      .osc_pin_in(osc_pin_in),
      .osc_pin_out(osc_pin_out),
      .count_wr(count_wr),
      .count_wdata(count_wdata),
      .count_value(count_value),
      .compare_wr(compare_wr),
      .compare_wdata(compare_wdata),
      .compare_rdata(compare_rdata),
      .force_compare_strobe(force_compare_strobe),
      .compare_irq_enable(compare_irq_enable),
      .overflow_irq_enable(overflow_irq_enable),
      .compare_flag_clr(compare_flag_clr),
      .overflow_flag_clr(overflow_flag_clr),
      .compare_irq_ack(compare_irq_ack),
      .overflow_irq_ack(overflow_irq_ack),
      .compare_match_flag(compare_match_flag),
      .overflow_flag(overflow_flag),
      .timer_flag_reg(timer_flag_reg),
      .timer_mask_reg(timer_mask_reg),
      .compare_irq(compare_irq),
      .overflow_irq(overflow_irq),
      .port_out(port_out),
      .pin_out(pin_out)
   );
   timer8_cpu_model cmp_cpu_u (.clk(clk), .sys_rst(sys_rst), .enable(svc), .latency(4'h0),
      .irq(compare_irq), .ack(compare_irq_ack));
   timer8_cpu_model ovf_cpu_u (.clk(clk), .sys_rst(sys_rst), .enable(svc), .latency(4'h9),
      .irq(overflow_irq), .ack(overflow_irq_ack));
   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task check(input [7:0] seen, input [7:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task step(input integer n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask
   task wait_cnt(input [7:0] v);
   begin
      for (i = 0; i < 600 && count_value !== v; i = i + 1)
         step(1);
      if (count_value !== v)
      begin
         err_count = err_count + 1;
         conclude;
      end
   end
   endtask
   task wr_cnt(input [7:0] v);
   begin
      count_wr = 1'b1;
      count_wdata = v;
      step(1);
      count_wr = 1'b0;
   end
   endtask
   task wr_cmp(input [7:0] v);
   begin
      compare_wr = 1'b1;
      compare_wdata = v;
      step(1);
      compare_wr = 1'b0;
   end
   endtask
   task force_pin(input [1:0] m);
   begin
      compare_output_mode = m;
      force_compare_strobe = 1'b1;
      step(1);
      force_compare_strobe = 1'b0;
      step(1);
   end
   endtask
   function next_pin(input [1:0] m, input cur);
   begin
      next_pin = (m == 2'h1) ? ~cur : m[0];
   end
   endfunction
   initial
   begin
      step(20);
      sys_rst = 1'b0;
      check(count_value, 8'h00);
      check(compare_rdata, 8'h00);
      check({6'h00, timer_flag_reg}, 8'h00);
      check({7'h00, pin_out}, 8'h01);
      c = $random(seed);
      wr_cnt(c);
      step(4);
      check(count_value, c);
      for (i = 0; i < 4; i = i + 1)
      begin
         waveform_mode_field = i[1:0];
         wr_cmp(c ^ i[7:0]);
         check(compare_rdata, c ^ i[7:0]);
      end
      waveform_mode_field = 2'h0;
      pin_exp = 1'b0;
      for (i = 3; i > 0; i = i - 1)
      begin
         pin_exp = next_pin(i[1:0], pin_exp);
         force_pin(i[1:0]);
         check({7'h00, pin_out}, {7'h00, pin_exp});
         check({7'h00, compare_match_flag}, 8'h00);
         check(count_value, c);
      end
      waveform_mode_field = 2'h3;
      force_pin(2'h2);
      check({7'h00, pin_out}, 8'h01);
      compare_output_mode = 2'h0;
      port_out = 1'b0;
      step(1);
      check({7'h00, pin_out}, 8'h00);
      waveform_mode_field = 2'h0;
      c = $random(seed);
      c = {3'h1, c[4:0]};
      wr_cmp(c);
      // equal count only while the output is unused
      wr_cnt(c);
      clock_select_field = 3'h1;
      step(5);
      check({7'h00, compare_match_flag}, 8'h00);
      wait_cnt(c + 8'h01);
      check({7'h00, compare_match_flag}, 8'h00);
      step(1);
      check({7'h00, compare_match_flag}, 8'h01);
      check({7'h00, compare_irq}, 8'h00);
      compare_irq_enable = 1'b1;
      overflow_irq_enable = 1'b1;
      step(1);
      check({7'h00, compare_irq}, 8'h01);
      check({6'h00, timer_mask_reg}, 8'h03);
      svc = 1'b1;
      step(3);
      check({7'h00, compare_match_flag}, 8'h00);
      wait_cnt(8'h00);
      check({7'h00, overflow_flag}, 8'h01);
      check({7'h00, overflow_irq}, 8'h01);
      step(12);
      check({7'h00, overflow_flag}, 8'h00);
      svc = 1'b0;
      wait_cnt(8'h00);
      wait_cnt(c + 8'h02);
      clock_select_field = 3'h0;
      step(2);
      check({6'h00, timer_flag_reg}, 8'h03);
      svc = 1'b1;
      step(3);
      svc = 1'b0;
      check({7'h00, compare_match_flag}, 8'h00);
      overflow_flag_clr = 1'b1;
      step(1);
      overflow_flag_clr = 1'b0;
      step(1);
      check({7'h00, overflow_flag}, 8'h00);
      waveform_mode_field = 2'h1;
      wr_cnt(8'hF0);
      clock_select_field = 3'h1;
      wait_cnt(8'hFF);
      step(2);
      check(count_value, 8'hFD);
      clock_select_field = 3'h0;
      waveform_mode_field = 2'h2;
      wr_cmp(c);
      wr_cnt(8'h00);
      clock_select_field = 3'h1;
      top_seen = 8'h00;
      for (i = 0; i < 200; i = i + 1)
      begin
         step(1);
         if (count_value > top_seen)
            top_seen = count_value;
      end
      check(top_seen, c);
      clock_select_field = 3'h0;
      waveform_mode_field = 2'h3;
      wr_cnt(8'hF8);
      wr_cmp(c ^ 8'hA5);
      clock_select_field = 3'h1;
      step(4);
      clock_select_field = 3'h0;
      waveform_mode_field = 2'h0;
      step(1);
      check(compare_rdata, c);
      waveform_mode_field = 2'h3;
      wr_cmp(c ^ 8'hA5);
      clock_select_field = 3'h1;
      wait_cnt(8'h02);
      clock_select_field = 3'h0;
      waveform_mode_field = 2'h0;
      step(1);
      check(compare_rdata, c ^ 8'hA5);
      async_clock_select = 1'b1;
      step(4);
      wr_cnt(8'h00);
      clock_select_field = 3'h1;
      for (i = 0; i < 8; i = i + 1)
      begin
         osc_pin_in = 1'b1;
         step(3);
         check({7'h00, osc_pin_out}, 8'h00);
         osc_pin_in = 1'b0;
         step(3);
      end
      step(4);
      check(count_value, 8'h08);
      check({7'h00, osc_pin_out}, 8'h01);
      conclude;
   end
endmodule
